// ===== logic/crbs_pkg.sv
// Constants, register map and types for the chip reset and brownout sequencer.
// Assumes a single 100 MHz clock and an APB slave with 32-bit data.
package crbs_pkg;
   localparam logic [11:0] CRBS_ADDR_CAUSE  = 12'h000;
   localparam logic [11:0] CRBS_ADDR_CLKSEL = 12'h004;
   localparam logic [11:0] CRBS_ADDR_WDMODE = 12'h008;
   localparam logic [11:0] CRBS_ADDR_WAKEEN = 12'h00c;
   localparam logic [11:0] CRBS_ADDR_STAT   = 12'h010;
   localparam logic [11:0] CRBS_ADDR_IRQEN  = 12'h014;
   localparam logic [11:0] CRBS_ADDR_IRQCLR = 12'h018;
   localparam logic [11:0] CRBS_ADDR_SUPPLY = 12'h01c;
   localparam int CRBS_CAUSE_PIN = 0;
   localparam int CRBS_CAUSE_WD  = 1;
   localparam int CRBS_CAUSE_POR = 2;
   localparam int CRBS_CAUSE_BOD = 3;
   localparam int CRBS_EV_BOD  = 0;
   localparam int CRBS_EV_WD   = 1;
   localparam int CRBS_EV_WAKE = 2;
   localparam int CRBS_NEV     = 3;
   localparam logic [1:0]  CRBS_CLK_IRC      = 2'h0;
   localparam logic [1:0]  CRBS_CLK_MAIN     = 2'h1;
   localparam logic [1:0]  CRBS_CLK_RTC      = 2'h2;
   localparam logic [31:0] CRBS_BOOT_VECTOR  = 32'h0000_0000;
   localparam logic [3:0]  CRBS_CAUSE_RST    = 4'h4;
   // Supply levels in millivolts; hysteresis is added on recovery
   localparam logic [11:0] CRBS_MV_BOD_IRQ   = 12'hb86;
   localparam logic [11:0] CRBS_MV_BOD_RST   = 12'ha5a;
   localparam logic [11:0] CRBS_MV_POR       = 12'h3e8;
   localparam logic [11:0] CRBS_MV_HYST      = 12'h032;
   // Supply synchroniser value after reset: above every threshold, so no false brownout
   localparam logic [11:0] CRBS_MV_SYNC_RST  = 12'hfff;
   localparam int          CRBS_WAKE_NS      = 10240;
   localparam int          CRBS_CLK_NS       = 10;
   localparam int          CRBS_WAKE_CYCLES  = (CRBS_WAKE_NS + CRBS_CLK_NS - 1) / CRBS_CLK_NS;
   typedef struct packed {
      logic       boot;
      logic [1:0] clk_src;
      logic       flash_lock;
   } crbs_core_ctl_t;
endpackage

// ===== logic/crbs_seq.sv
// Chip reset and brownout sequencer with APB register slave.
// Assumes supply level words and detector inputs come from analog monitors
// asynchronous to the clock; the core, flash and watchdog are on this clock.
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ns
module crbs_seq import crbs_pkg::*; #(
   parameter int WAKE_CYCLES = CRBS_WAKE_CYCLES,
   parameter int NEXT        = 4
) (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              rst,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic [31:0]            prdata,
   // Reset sources and monitors
   input  wire logic              reset_pin_n,
   input  wire logic              por_req,
   input  wire logic [11:0]       core_supply_mv,
   input  wire logic              osc_running,
   input  wire logic              flash_init_done,
   input  wire logic              wd_feed_error,
   input  wire logic [NEXT-1:0]   ext_irq,
   input  wire logic              power_down,
   // Core side
   output logic                   chip_reset,
   output logic [31:0]            fetch_addr,
   output crbs_core_ctl_t         core_ctl,
   output logic                   brownout_detector_irq,
   output logic                   wake_up,
   output logic                   irq
);
   typedef enum logic [1:0] {S_HOLD, S_WAIT, S_RUN} crbs_state_t;

   // Async inputs through two flops before any logic reads them
   logic [1:0]      pin_s1_q;
   logic [1:0]      pin_s2_q;
   logic [1:0]      por_s1_q;
   logic [1:0]      por_s2_q;
   logic [1:0]      osc_s1_q;
   logic [1:0]      osc_s2_q;
   logic [11:0]     mv_s1_q;
   logic [11:0]     mv_s2_q;
   logic [NEXT-1:0] ext_s1_q;
   logic [NEXT-1:0] ext_s2_q;
   logic            pin_rst;
   logic            por_rst;
   assign pin_rst = pin_s2_q[0];
   assign por_rst = por_s2_q[0];

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pin_s1_q <= 2'h0;
         pin_s2_q <= 2'h0;
      end else begin
         pin_s1_q <= {1'b0, ~reset_pin_n};
         pin_s2_q <= pin_s1_q;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         por_s1_q <= 2'h0;
         por_s2_q <= 2'h0;
      end else begin
         por_s1_q <= {1'b0, por_req};
         por_s2_q <= por_s1_q;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         osc_s1_q <= 2'h0;
         osc_s2_q <= 2'h0;
      end else begin
         osc_s1_q <= {1'b0, osc_running};
         osc_s2_q <= osc_s1_q;
      end
   end

   // Starts high so the comparators see no brownout before the first sample
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mv_s1_q <= CRBS_MV_SYNC_RST;
         mv_s2_q <= CRBS_MV_SYNC_RST;
      end else begin
         mv_s1_q <= core_supply_mv;
         mv_s2_q <= mv_s1_q;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ext_s1_q <= '0;
         ext_s2_q <= '0;
      end else begin
         ext_s1_q <= ext_irq;
         ext_s2_q <= ext_s1_q;
      end
   end

   // Brownout comparators with hysteresis; a multi-bit level word is
   // assumed to move slowly enough that double sampling is coherent
   logic bod_irq_q, bod_irq_d, bod_rst_q, bod_rst_d;
   always_comb begin
      bod_irq_d = bod_irq_q;
      bod_rst_d = bod_rst_q;
      if (mv_s2_q < CRBS_MV_BOD_IRQ)
         bod_irq_d = 1'b1;
      else if (mv_s2_q >= CRBS_MV_BOD_IRQ + CRBS_MV_HYST)
         bod_irq_d = 1'b0;
      if (mv_s2_q < CRBS_MV_BOD_RST && mv_s2_q >= CRBS_MV_POR)
         bod_rst_d = 1'b1;
      else if (mv_s2_q < CRBS_MV_POR)
         bod_rst_d = 1'b0;
      else if (mv_s2_q >= CRBS_MV_BOD_RST + CRBS_MV_HYST)
         bod_rst_d = 1'b0;
   end

   // Registers
   logic [3:0]          cause_q, cause_d;
   logic [1:0]          clksel_q, clksel_d;
   logic [1:0]          wdmode_q, wdmode_d;
   logic [NEXT-1:0]     wakeen_q, wakeen_d;
   logic [CRBS_NEV-1:0] stat_q, stat_d, irqen_q, irqen_d;
   logic [31:0]         prdata_q, prdata_d;
   logic                ack_q, ack_d;
   logic                wd_rst, wr, rd;
   logic [CRBS_NEV-1:0] ev;

   // One wait state, so read data is already registered when pready is high
   always_comb begin
      ack_d = psel & penable & ~ack_q;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= ack_d;
      end
   end

   // Writes land on the completing edge, read data is captured one edge earlier
   assign wr     = psel & penable & pwrite & ack_q;
   assign rd     = psel & penable & ~pwrite & ~ack_q;
   assign wd_rst = wd_feed_error & wdmode_q[1];
   assign ev[CRBS_EV_BOD]  = bod_irq_q;
   assign ev[CRBS_EV_WD]   = wd_feed_error & wdmode_q[0];
   assign ev[CRBS_EV_WAKE] = power_down & |(ext_s2_q & wakeen_q);

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction

   // Sequencer
   crbs_state_t st_q, st_d;
   logic [15:0] cnt_q, cnt_d;
   logic        any_req;
   assign any_req = pin_rst | por_rst | bod_rst_q | wd_rst;

   always_comb begin
      st_d  = st_q;
      cnt_d = cnt_q;
      case (st_q)
         S_HOLD: begin
            cnt_d = 16'h0000;
            if (!any_req)
               st_d = S_WAIT;
         end
         S_WAIT: begin
            cnt_d = cnt_q + 16'h0001;
            if (any_req)
               st_d = S_HOLD;
            else if (osc_s2_q[0] && flash_init_done && cnt_q >= 16'(WAKE_CYCLES - 1))
               st_d = S_RUN;
         end
         S_RUN: begin
            if (any_req)
               st_d = S_HOLD;
         end
         default: st_d = S_HOLD;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_q  <= S_HOLD;
         cnt_q <= 16'h0000;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         bod_irq_q <= 1'b0;
         bod_rst_q <= 1'b0;
      end else begin
         bod_irq_q <= bod_irq_d;
         bod_rst_q <= bod_rst_d;
      end
   end

   // Cause and status flags; a set wins over a same-cycle software clear
   always_comb begin
      cause_d = cause_q;
      stat_d  = stat_q;
      if (wr && hit(paddr, CRBS_ADDR_CAUSE))
         cause_d = cause_q & ~pwdata[3:0];
      if (wr && hit(paddr, CRBS_ADDR_IRQCLR))
         stat_d = stat_q & ~pwdata[CRBS_NEV-1:0];
      stat_d = stat_d | ev;
      if (pin_rst)
         cause_d[CRBS_CAUSE_PIN] = 1'b1;
      if (wd_rst)
         cause_d[CRBS_CAUSE_WD] = 1'b1;
      if (por_rst)
         cause_d[CRBS_CAUSE_POR] = 1'b1;
      if (bod_rst_q)
         cause_d[CRBS_CAUSE_BOD] = 1'b1;
   end

   // Configuration, held at its reset values from the second cycle of chip reset until release
   always_comb begin
      clksel_d = clksel_q;
      wdmode_d = wdmode_q;
      wakeen_d = wakeen_q;
      irqen_d  = irqen_q;
      if (wr && hit(paddr, CRBS_ADDR_CLKSEL) && pwdata[1:0] != 2'h3)
         clksel_d = pwdata[1:0];
      if (wr && hit(paddr, CRBS_ADDR_WDMODE))
         wdmode_d = pwdata[1:0];
      if (wr && hit(paddr, CRBS_ADDR_WAKEEN))
         wakeen_d = pwdata[NEXT-1:0];
      if (wr && hit(paddr, CRBS_ADDR_IRQEN))
         irqen_d = pwdata[CRBS_NEV-1:0];
      if (st_q != S_RUN) begin
         clksel_d = CRBS_CLK_IRC;
         wdmode_d = 2'h0;
         wakeen_d = '0;
         irqen_d  = '0;
      end
   end

   // Read mux; the word stands one cycle and then returns to zero
   always_comb begin
      prdata_d = 32'h0000_0000;
      if (rd) begin
         case (paddr)
            CRBS_ADDR_CAUSE:  prdata_d = {28'h0, cause_q};
            CRBS_ADDR_CLKSEL: prdata_d = {30'h0, clksel_q};
            CRBS_ADDR_WDMODE: prdata_d = {30'h0, wdmode_q};
            CRBS_ADDR_WAKEEN: prdata_d = 32'(wakeen_q);
            CRBS_ADDR_STAT:   prdata_d = {29'h0, stat_q};
            CRBS_ADDR_IRQEN:  prdata_d = {29'h0, irqen_q};
            CRBS_ADDR_SUPPLY: prdata_d = {20'h0, mv_s2_q};
            default:          prdata_d = 32'h0000_0000;
         endcase
      end
   end

   // Cause flags reset only with the power-on level, so they outlive chip reset
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cause_q   <= CRBS_CAUSE_RST;
         clksel_q  <= CRBS_CLK_IRC;
         wdmode_q  <= 2'h0;
         wakeen_q  <= '0;
         stat_q    <= '0;
         irqen_q   <= '0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         cause_q   <= cause_d;
         clksel_q  <= clksel_d;
         wdmode_q  <= wdmode_d;
         wakeen_q  <= wakeen_d;
         stat_q    <= stat_d;
         irqen_q   <= irqen_d;
         prdata_q  <= prdata_d;
      end
   end

   // Outputs; reset release follows a registered state, hence synchronous
   assign chip_reset            = (st_q != S_RUN);
   assign fetch_addr            = CRBS_BOOT_VECTOR;
   assign core_ctl.boot         = (st_q == S_RUN);
   assign core_ctl.clk_src      = clksel_q;
   assign core_ctl.flash_lock   = bod_rst_q;
   assign brownout_detector_irq = bod_irq_q;
   assign wake_up               = stat_q[CRBS_EV_WAKE];
   assign irq                   = |(stat_q & irqen_q);
   assign pready                = ack_q;
   assign pslverr               = 1'b0;
   assign prdata                = prdata_q;
endmodule

// ===== tb/crbs_core_model.sv
// Core and interrupt controller stand-in.
// Assumes the sequencer's core side on the same clock.
`timescale 1ns/1ns
module crbs_core_model import crbs_pkg::*; (
   // Sequencer side
   input wire logic        clock,
   input wire logic        chip_reset,
   input wire logic [31:0] fetch_addr,
   input wire logic        brownout_detector_irq,
   input wire logic        wake_up,
   // Bench commands
   input wire logic        sleep_req,
   input wire logic        vic_bod_en,
   // Observed state
   output logic            power_down,
   output logic [31:0]     boot_addr,
   output logic            cpu_int
);
   assign cpu_int = brownout_detector_irq & vic_bod_en;
   always_ff @(posedge clock) begin
      if (chip_reset) begin
         boot_addr <= 32'hffff_ffff;
         power_down <= 1'b0;
      end else begin
         // First fetch after release only
         if (boot_addr == 32'hffff_ffff) boot_addr <= fetch_addr;
         if (sleep_req) power_down <= 1'b1;
         else if (wake_up) power_down <= 1'b0;
      end
   end
endmodule

// ===== tb/crbs_seq_bench.sv
// Self-checking bench for the reset sequencer.
// Assumes 100 MHz and a wake-up count cut to 8.
`timescale 1ns/1ns
module crbs_seq_bench import crbs_pkg::*;;
   logic           clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic           pin_n = 1'b1, por = 1'b0, wde = 1'b0, slp = 1'b0, ven = 1'b1;
   logic           osc = 1'b0, fl = 1'b0;
   logic [11:0]    paddr = 12'h000, mv = 12'hce4;
   logic [31:0]    pwdata = 32'h0, prdata, fetch_addr, boot;
   logic [3:0]     ext = 4'h0;
   logic           pready, pslverr, chip_reset, bdi, wake_up, irq, pd, cint;
   crbs_core_ctl_t core_ctl;
   int             err_total = 0, check_count = 0, cyc = 0;
   wire  [4:0]     obs = {cint, wake_up, irq, bdi, chip_reset};
   crbs_seq #(.WAKE_CYCLES(8), .NEXT(4)) DUT (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .reset_pin_n(pin_n), .por_req(por), .core_supply_mv(mv), .osc_running(osc), .flash_init_done(fl),
      .wd_feed_error(wde), .ext_irq(ext), .power_down(pd), .chip_reset(chip_reset), .fetch_addr(fetch_addr),
      .core_ctl(core_ctl), .brownout_detector_irq(bdi), .wake_up(wake_up), .irq(irq));
   crbs_core_model u_core (.clock(clock), .chip_reset(chip_reset), .fetch_addr(fetch_addr),
      .brownout_detector_irq(bdi), .wake_up(wake_up), .sleep_req(slp), .vic_bod_en(ven),
      .power_down(pd), .boot_addr(boot), .cpu_int(cint));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Read data is taken at the edge where pready is seen high
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      if (!w) chk(prdata, e);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic wt(input int i, input logic v);
      int n;
      n = 0;
      while (obs[i] !== v && n < 300) begin
         @(posedge clock);
         n++;
      end
      chk(obs[i], v);
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         stop_test();
      end
   end
   initial begin
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      repeat (20) @(posedge clock);
      chk(chip_reset, 1'b1);
      osc <= 1'b1;
      repeat (20) @(posedge clock);
      chk(chip_reset, 1'b1);
      fl <= 1'b1;
      wt(0, 1'b0);
      @(posedge clock);
      chk(boot, CRBS_BOOT_VECTOR);
      xfer(0, CRBS_ADDR_CAUSE, 0, 32'h4);
      for (int s = 1; s <= 3; s++) begin
         xfer(1, CRBS_ADDR_CLKSEL, s, 0);
         xfer(0, CRBS_ADDR_CLKSEL, 0, s == 3 ? 2 : s);
      end
      xfer(0, 12'h020, 0, 0);
      pin_n <= 1'b0;
      wt(0, 1'b1);
      pin_n <= 1'b1;
      repeat (6) @(posedge clock);
      chk(chip_reset, 1'b1);
      wt(0, 1'b0);
      xfer(0, CRBS_ADDR_CLKSEL, 0, 0);
      xfer(0, CRBS_ADDR_CAUSE, 0, 32'h5);
      xfer(1, CRBS_ADDR_CAUSE, 32'hf, 0);
      xfer(0, CRBS_ADDR_CAUSE, 0, 0);
      mv <= 12'hb54;
      wt(1, 1'b1);
      xfer(0, CRBS_ADDR_STAT, 0, 32'h1);
      xfer(1, CRBS_ADDR_IRQEN, 32'h1, 0);
      wt(2, 1'b1);
      wt(4, 1'b1);
      mv <= 12'hb90;
      repeat (6) @(posedge clock);
      chk(bdi, 1'b1);
      mv <= 12'hce4;
      wt(1, 1'b0);
      xfer(1, CRBS_ADDR_IRQCLR, 32'h7, 0);
      wt(2, 1'b0);
      for (int w = 1; w <= 2; w++) begin
         xfer(1, CRBS_ADDR_WDMODE, w, 0);
         xfer(1, CRBS_ADDR_IRQEN, 32'h2, 0);
         wde <= 1'b1;
         @(posedge clock);
         wde <= 1'b0;
         wt(w == 1 ? 2 : 0, 1'b1);
         xfer(1, CRBS_ADDR_IRQCLR, 32'h2, 0);
      end
      wt(0, 1'b0);
      xfer(0, CRBS_ADDR_CAUSE, 0, 32'h2);
      mv <= 12'ha28;
      wt(0, 1'b1);
      mv <= 12'h1f4;
      por <= 1'b1;
      repeat (20) @(posedge clock);
      chk(chip_reset, 1'b1);
      por <= 1'b0;
      mv <= 12'hce4;
      wt(0, 1'b0);
      xfer(0, CRBS_ADDR_CAUSE, 0, 32'he);
      xfer(1, CRBS_ADDR_IRQCLR, 32'h7, 0);
      xfer(1, CRBS_ADDR_WAKEEN, 32'h1, 0);
      slp <= 1'b1;
      @(posedge clock);
      slp <= 1'b0;
      ext <= 4'h1;
      wt(3, 1'b1);
      ext <= 4'h0;
      xfer(0, CRBS_ADDR_STAT, 0, 32'h4);
      chk(pd, 1'b0);
      stop_test();
   end
endmodule

// ===== tb/crbs_seq_properties.sv
// Port checker for the reset sequencer.
// Assumes one clock and an async active-high rst.
`timescale 1ns/1ns
module crbs_chk import crbs_pkg::*; #(
   parameter int WAKE_CYCLES = 8,
   parameter int NEXT        = 4
) (
   // Inputs of the sequencer
   input wire logic            clock,
   input wire logic            rst,
   input wire logic            reset_pin_n,
   input wire logic            por_req,
   input wire logic [11:0]     core_supply_mv,
   input wire logic            osc_running,
   input wire logic            flash_init_done,
   input wire logic [NEXT-1:0] ext_irq,
   // Outputs of the sequencer
   input wire logic            chip_reset,
   input wire logic [31:0]     fetch_addr,
   input wire crbs_core_ctl_t  core_ctl,
   input wire logic            brownout_detector_irq,
   input wire logic            wake_up,
   input wire logic            irq
);
   logic ok;
   int   ok_q;
   int   ok_d;
   // Longer than the design's view, since the design adds sync delay
   always_comb begin
      ok = reset_pin_n && !por_req && core_supply_mv >= CRBS_MV_BOD_RST;
      ok_d = ok ? ok_q + 1 : 0;
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) ok_q <= 0;
      else ok_q <= ok_d;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   property p_pin; !reset_pin_n[*2] |-> ##[0:3] chip_reset; endproperty
   a_pin: assert property (p_pin) else $error("pin low, no reset");
   property p_por; por_req[*2] |-> ##[0:3] chip_reset; endproperty
   a_por: assert property (p_por) else $error("power-on, no reset");
   property p_wait; $fell(chip_reset) |-> ok_q >= WAKE_CYCLES; endproperty
   a_wait: assert property (p_wait) else $error("early release");
   property p_rdy; $fell(chip_reset) |-> osc_running && flash_init_done; endproperty
   a_rdy: assert property (p_rdy) else $error("release before ready");
   property p_vec; $fell(chip_reset) |-> fetch_addr == CRBS_BOOT_VECTOR; endproperty
   a_vec: assert property (p_vec) else $error("bad fetch address");
   property p_irc; chip_reset[*3] |-> core_ctl.clk_src == CRBS_CLK_IRC; endproperty
   a_irc: assert property (p_irc) else $error("clock not internal");
   property p_quiet; chip_reset[*3] |-> !irq; endproperty
   a_quiet: assert property (p_quiet) else $error("irq in reset");
   property p_bi; (core_supply_mv < CRBS_MV_BOD_IRQ && !chip_reset)[*3] |-> ##[0:3] brownout_detector_irq; endproperty
   a_bi: assert property (p_bi) else $error("no brownout irq");
   property p_br; (core_supply_mv < CRBS_MV_BOD_RST && core_supply_mv >= CRBS_MV_POR)[*3] |-> ##[0:3] chip_reset; endproperty
   a_br: assert property (p_br) else $error("no brownout reset");
   property p_wk; $rose(wake_up) |-> |{$past(ext_irq, 1), $past(ext_irq, 2), $past(ext_irq, 3), $past(ext_irq, 4)}; endproperty
   a_wk: assert property (p_wk) else $error("wake without input");
endmodule
bind crbs_seq crbs_chk #(.WAKE_CYCLES(WAKE_CYCLES), .NEXT(NEXT)) u_chk (.clock(clock), .rst(rst),
   .reset_pin_n(reset_pin_n), .por_req(por_req), .core_supply_mv(core_supply_mv), .osc_running(osc_running),
   .flash_init_done(flash_init_done), .ext_irq(ext_irq), .chip_reset(chip_reset), .fetch_addr(fetch_addr),
   .core_ctl(core_ctl), .brownout_detector_irq(brownout_detector_irq), .wake_up(wake_up), .irq(irq));
